// ### verilog/arct_pkg.sv
// constants for the auto-reload/capture/baud timer
package arct_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CONTROL = 8'hc8;
  localparam logic [7:0] OFF_COUNT_LOW = 8'hcc;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'hd0;
  localparam logic [7:0] OFF_RELOAD_LOW = 8'hd4;
  localparam logic [7:0] OFF_RELOAD_HIGH = 8'hd8;
  localparam logic [7:0] OFF_SYSTEM = 8'hdc;
  localparam int BIT_CAP_RELOAD = 0;
  localparam int BIT_CLK_SRC = 1;
  localparam int BIT_RUN = 2;
  localparam int BIT_TRIG_EN = 3;
  localparam int BIT_TX_SEL = 4;
  localparam int BIT_RX_SEL = 5;
  localparam int BIT_EXT_FLAG = 6;
  localparam int BIT_OVF_FLAG = 7;
  localparam int BIT_POWER_DOWN = 0;
  localparam int BIT_SER_MODE_LO = 1;
  localparam int BIT_SER_MODE_HI = 2;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [2:0] SYSTEM_RESET = 3'h0;
  localparam logic [3:0] PHASES_PER_CYCLE = 4'hc;
  localparam logic [3:0] PHASE_LAST = 4'hb;
  localparam logic [3:0] PHASE_S2 = 4'h2;
  localparam logic [3:0] PHASE_S3 = 4'h4;
  localparam logic [3:0] PHASE_S4 = 4'h6;
  localparam logic [3:0] PHASE_S5 = 4'h8;
endpackage

// ### verilog/arct_fall_detect.sv
// pin falling-edge detector aligned to machine-cycle state phases
module arct_fall_detect #(
  parameter logic [3:0] PASS_PHASE = 4'h8,
  parameter logic [3:0] ISSUE_PHASE = 4'h4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pinLevel,
  input wire logic [3:0] phase,
  output logic eventPulse
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic latch_reg;
  logic pass_reg;
  wire fallSeen = prev_reg & ~sync2_reg;
  wire atPass = (phase == PASS_PHASE);
  wire atIssue = (phase == ISSUE_PHASE);

  if (PASS_PHASE == ISSUE_PHASE || PASS_PHASE > arct_pkg::PHASE_LAST || ISSUE_PHASE > arct_pkg::PHASE_LAST) begin
    $error("pass and issue phases must differ and lie within one machine cycle");
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      sync1_reg <= pinLevel;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // a fall arriving on the clearing phase is kept, not lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_reg <= 1'b0;
      pass_reg <= 1'b0;
      eventPulse <= 1'b0;
    end else begin
      latch_reg <= fallSeen | (latch_reg & ~(atIssue & pass_reg));
      if (atPass) begin
        pass_reg <= latch_reg;
      end else if (atIssue) begin
        pass_reg <= 1'b0;
      end
      eventPulse <= atIssue & pass_reg;
    end
  end
endmodule

// ### verilog/arct_timer2.sv
// 16-bit auto-reload / capture / baud-rate timer with avalon-mm register slave
// Function
// - 16-bit counter as low and high byte, both readable and writable.
// - rate selects both zero and capture/reload select one gives capture mode.
// - any rate select forces baud mode; otherwise select zero gives auto-reload.
// - run control zero halts all counting; one enables it.
// - clock source select: zero internal clock, one synchronised count pin.
// - trigger enable zero ignores trigger pin falls; one lets them act.
// - auto-reload: carry or enabled trigger fall loads reload pair into counter.
// - capture: enabled trigger fall copies count into reload/capture pair.
// - auto-reload and capture: carry sets overflow flag, control bit 7.
// - any mode: enabled trigger fall sets external flag, control bit 6.
// - either flag requests timer interrupt; only software clears flags.
// - baud mode reloads on carry; carry goes to receiver/transmitter by select.
// - rate clocks used only in serial modes 1 and 3.
// - baud mode never sets overflow flag; trigger still sets external flag.
// - baud mode internal clock counts at half oscillator rate.
// - count pin fall latched, passed at phase five, counted at phase three.
// - trigger pin fall latched, passed at phase two, issued at phase four.
// - counting stops in the power-down mode that halts the oscillator.
//
// Design decision made here: the Avalon-MM register port.
module arct_timer2 (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic countPin,
  input wire logic triggerPin,
  output logic timerIrq,
  output logic rxRateTick,
  output logic txRateTick
);
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] reload_reg;
  logic [15:0] reload_next;
  logic [2:0] system_reg;
  logic [3:0] phase_reg;
  logic countPinTick;
  logic triggerEvent;

  // one comparison shared by every register select
  function automatic logic hitAddr(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  // bus decode
  wire request = avs_read | avs_write;
  wire accept = request & avs_waitrequest;
  wire writeNow = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire [7:0] wdata = avs_writedata[7:0];
  wire selControl = hitAddr(avs_address, arct_pkg::OFF_CONTROL);
  wire selCountLow = hitAddr(avs_address, arct_pkg::OFF_COUNT_LOW);
  wire selCountHigh = hitAddr(avs_address, arct_pkg::OFF_COUNT_HIGH);
  wire selReloadLow = hitAddr(avs_address, arct_pkg::OFF_RELOAD_LOW);
  wire selReloadHigh = hitAddr(avs_address, arct_pkg::OFF_RELOAD_HIGH);
  wire selSystem = hitAddr(avs_address, arct_pkg::OFF_SYSTEM);
  wire wrControl = writeNow & selControl;
  wire wrCountLow = writeNow & selCountLow;
  wire wrCountHigh = writeNow & selCountHigh;
  wire wrReloadLow = writeNow & selReloadLow;
  wire wrReloadHigh = writeNow & selReloadHigh;
  wire wrSystem = writeNow & selSystem;
  wire wrCount = wrCountLow | wrCountHigh;
  logic [7:0] readMux;

  always_comb begin
    if (selControl) begin
      readMux = control_reg;
    end else if (selCountLow) begin
      readMux = count_reg[7:0];
    end else if (selCountHigh) begin
      readMux = count_reg[15:8];
    end else if (selReloadLow) begin
      readMux = reload_reg[7:0];
    end else if (selReloadHigh) begin
      readMux = reload_reg[15:8];
    end else if (selSystem) begin
      readMux = {5'h00, system_reg};
    end else begin
      readMux = 8'h00;
    end
  end

  // one wait cycle per access, so read data always stand on a registered mux
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~accept;
      if (accept) begin
        avs_readdata <= {24'h000000, readMux};
      end
    end
  end

  // mode and clock selection
  wire captureSel = control_reg[arct_pkg::BIT_CAP_RELOAD];
  wire clockSrcSel = control_reg[arct_pkg::BIT_CLK_SRC];
  wire runControl = control_reg[arct_pkg::BIT_RUN];
  wire triggerEnable = control_reg[arct_pkg::BIT_TRIG_EN];
  wire txSel = control_reg[arct_pkg::BIT_TX_SEL];
  wire rxSel = control_reg[arct_pkg::BIT_RX_SEL];
  wire extFlag = control_reg[arct_pkg::BIT_EXT_FLAG];
  wire ovfFlag = control_reg[arct_pkg::BIT_OVF_FLAG];
  wire powerDown = system_reg[arct_pkg::BIT_POWER_DOWN];
  wire serialOddMode = system_reg[arct_pkg::BIT_SER_MODE_LO];
  wire baudMode = rxSel | txSel;
  wire captureMode = ~baudMode & captureSel;
  wire reloadMode = ~baudMode & ~captureSel;
  wire running = runControl & ~powerDown;

  // machine-cycle phase: twelve oscillator periods, two per state phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= 4'h0;
    end else if (phase_reg == arct_pkg::PHASE_LAST) begin
      phase_reg <= 4'h0;
    end else begin
      phase_reg <= phase_reg + 4'h1;
    end
  end

  wire machineTick = (phase_reg == arct_pkg::PHASE_LAST);
  wire halfOscTick = phase_reg[0];
  wire internalTick = baudMode ? halfOscTick : machineTick;
  wire selTick = clockSrcSel ? countPinTick : internalTick;
  wire countStep = running & selTick;
  wire carry = countStep & (count_reg == 16'hffff);
  wire trigValid = triggerEvent & triggerEnable;
  wire reloadLoad = carry & ~captureMode | trigValid & reloadMode & running;
  wire captureLoad = trigValid & captureMode & running;

  arct_fall_detect #(
    .PASS_PHASE(arct_pkg::PHASE_S5),
    .ISSUE_PHASE(arct_pkg::PHASE_S3)
  ) countDetect (
    .clk(clk),
    .rstn(rstn),
    .pinLevel(countPin),
    .phase(phase_reg),
    .eventPulse(countPinTick)
  );

  arct_fall_detect #(
    .PASS_PHASE(arct_pkg::PHASE_S2),
    .ISSUE_PHASE(arct_pkg::PHASE_S4)
  ) triggerDetect (
    .clk(clk),
    .rstn(rstn),
    .pinLevel(triggerPin),
    .phase(phase_reg),
    .eventPulse(triggerEvent)
  );

  // counter: software byte write beats hardware for that byte
  always_comb begin
    count_next = count_reg;
    if (reloadLoad) begin
      count_next = reload_reg;
    end else if (countStep) begin
      count_next = count_reg + 16'h0001;
    end
    if (wrCountLow) begin
      count_next[7:0] = wdata;
    end
    if (wrCountHigh) begin
      count_next[15:8] = wdata;
    end
  end

  always_comb begin
    reload_next = reload_reg;
    if (captureLoad) begin
      reload_next = count_reg;
    end
    if (wrReloadLow) begin
      reload_next[7:0] = wdata;
    end
    if (wrReloadHigh) begin
      reload_next[15:8] = wdata;
    end
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_comb begin
    control_next = control_reg;
    if (wrControl) begin
      control_next = wdata;
    end
    if (carry & ~baudMode) begin
      control_next[arct_pkg::BIT_OVF_FLAG] = 1'b1;
    end
    if (trigValid) begin
      control_next[arct_pkg::BIT_EXT_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_reg <= arct_pkg::CONTROL_RESET;
      count_reg <= arct_pkg::COUNT_RESET;
      reload_reg <= arct_pkg::RELOAD_RESET;
      system_reg <= arct_pkg::SYSTEM_RESET;
    end else begin
      control_reg <= control_next;
      count_reg <= count_next;
      reload_reg <= reload_next;
      if (wrSystem) begin
        system_reg <= wdata[2:0];
      end
    end
  end

  // outputs held in flops; rate ticks last one cycle per carry
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timerIrq <= 1'b0;
      rxRateTick <= 1'b0;
      txRateTick <= 1'b0;
    end else begin
      timerIrq <= ovfFlag | extFlag;
      rxRateTick <= carry & baudMode & rxSel & serialOddMode;
      txRateTick <= carry & baudMode & txSel & serialOddMode;
    end
  end

  // checks
  sequence sCarryNoWrite;
    carry & ~captureMode & ~wrCount;
  endsequence

  sequence sCaptureEdge;
    captureLoad & ~wrReloadLow & ~wrReloadHigh;
  endsequence

  property pReloadOnCarry;
    @(posedge clk) disable iff (!rstn)
    sCarryNoWrite |=> count_reg == $past(reload_reg);
  endproperty

  AST_RELOAD_ON_CARRY: assert property (pReloadOnCarry) else $error("carry did not reload counter");

  AST_CAPTURE_COPY: assert property (@(posedge clk) disable iff (!rstn)
    sCaptureEdge |=> reload_reg == $past(count_reg)) else $error("capture did not copy count");

  AST_OVF_SET: assert property (@(posedge clk) disable iff (!rstn)
    carry & ~baudMode |=> ovfFlag [*1] ##1 timerIrq) else $error("overflow flag or request missing");

  AST_NO_OVF_BAUD: assert property (@(posedge clk) disable iff (!rstn)
    carry & baudMode & ~ovfFlag & ~wrControl |=> ~ovfFlag) else $error("overflow flag set in baud mode");

  AST_EXT_FLAG: assert property (@(posedge clk) disable iff (!rstn)
    triggerEvent & triggerEnable |=> extFlag) else $error("external flag not set");

  AST_HALT: assert property (@(posedge clk) disable iff (!rstn)
    ~running & ~wrCount & ~(trigValid & reloadMode) |=> $stable(count_reg)) else $error("counter moved while halted");

  AST_INCREMENT: assert property (@(posedge clk) disable iff (!rstn)
    countStep & ~reloadLoad & ~wrCount |=> count_reg == $past(count_reg) + 16'h0001) else $error("bad increment");

  AST_RX_TICK: assert property (@(posedge clk) disable iff (!rstn)
    carry & baudMode & rxSel & serialOddMode |=> rxRateTick ##1 ~rxRateTick) else $error("receive tick wrong");

  AST_COUNT_PHASE: assert property (@(posedge clk) disable iff (!rstn)
    countPinTick |-> $past(phase_reg) == arct_pkg::PHASE_S3) else $error("count pin tick off phase");

  AST_TRIG_PHASE: assert property (@(posedge clk) disable iff (!rstn)
    triggerEvent |-> $past(phase_reg) == arct_pkg::PHASE_S4) else $error("trigger event off phase");

  AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (!rstn)
    request & avs_waitrequest |=> ~avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing wrong");

  sequence sTxPulse;
    txRateTick ##1 ~txRateTick;
  endsequence

  AST_TX_TICK: assert property (@(posedge clk) disable iff (!rstn)
    carry & baudMode & txSel & serialOddMode |=> sTxPulse) else $error("transmit tick wrong");

  AST_IRQ_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> timerIrq == $past(ovfFlag | extFlag)) else $error("request does not follow flags");

  AST_OVF_STICKY: assert property (@(posedge clk) disable iff (!rstn)
    ovfFlag & ~wrControl |=> ovfFlag) else $error("overflow flag cleared by hardware");

  AST_EXT_STICKY: assert property (@(posedge clk) disable iff (!rstn)
    extFlag & ~wrControl |=> extFlag) else $error("external flag cleared by hardware");

  AST_EVEN_MODE_QUIET: assert property (@(posedge clk) disable iff (!rstn)
    ~serialOddMode |=> ~rxRateTick & ~txRateTick) else $error("rate tick outside serial modes 1 and 3");

  AST_CAPTURE_WRAP: assert property (@(posedge clk) disable iff (!rstn)
    carry & captureMode & ~wrCount |=> count_reg == 16'h0000) else $error("capture mode carry did not wrap");

  AST_TRIG_IGNORED: assert property (@(posedge clk) disable iff (!rstn)
    triggerEvent & ~triggerEnable & ~extFlag & ~wrControl |=> ~extFlag) else $error("disabled trigger set flag");

  AST_BAUD_HALF_RATE: assert property (@(posedge clk) disable iff (!rstn)
    baudMode & ~clockSrcSel & ~halfOscTick & ~wrCount |=> $stable(count_reg)) else $error("baud count off half rate");

  AST_READ_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    ~avs_waitrequest |-> avs_readdata[31:8] == 24'h000000) else $error("read data upper bits not zero");

  AST_CAPTURE_HOLDS: assert property (@(posedge clk) disable iff (!rstn)
    trigValid & captureMode & ~countStep & ~wrCount |=> $stable(count_reg)) else $error("capture moved counter");

  AST_BYTE_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    wrCountLow |=> count_reg[7:0] == $past(wdata)) else $error("count low byte write lost");

  AST_POWER_HALT: assert property (@(posedge clk) disable iff (!rstn)
    powerDown & ~wrCount |=> $stable(count_reg)) else $error("counter moved in power-down");

  // spacing of pin counts; saturates so a long gap never wraps into a false failure
  logic [3:0] countGap_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      countGap_reg <= arct_pkg::PHASE_LAST;
    end else if (countPinTick) begin
      countGap_reg <= 4'h0;
    end else if (countGap_reg != arct_pkg::PHASE_LAST) begin
      countGap_reg <= countGap_reg + 4'h1;
    end
  end

  AST_COUNT_SPACING: assert property (@(posedge clk) disable iff (!rstn)
    countPinTick |-> countGap_reg == arct_pkg::PHASE_LAST) else $error("two pin counts in one machine cycle");

  // same spacing watch for trigger events
  logic [3:0] trigGap_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trigGap_reg <= arct_pkg::PHASE_LAST;
    end else if (triggerEvent) begin
      trigGap_reg <= 4'h0;
    end else if (trigGap_reg != arct_pkg::PHASE_LAST) begin
      trigGap_reg <= trigGap_reg + 4'h1;
    end
  end

  AST_TRIG_SPACING: assert property (@(posedge clk) disable iff (!rstn)
    triggerEvent |-> trigGap_reg == arct_pkg::PHASE_LAST) else $error("two trigger events in one machine cycle");
endmodule

// ### dv/arct_pin_source.sv
// behavioural source for the count and trigger pins
module arct_pin_source (
  input wire logic clk,
  output logic countPin,
  output logic triggerPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // longer holds model a slow source
  int holdCycles = 12;
  initial begin
    countPin = 1'b1;
    triggerPin = 1'b1;
  end
  // each level held at least twelve clocks, else falls may be lost
  task automatic fall(input bit trig, input int n);
    repeat (n) begin
      if (trig) triggerPin <= 1'b0;
      else countPin <= 1'b0;
      repeat (holdCycles) @(posedge clk);
      if (trig) triggerPin <= 1'b1;
      else countPin <= 1'b1;
      repeat (holdCycles) @(posedge clk);
    end
  endtask
endmodule

// ### dv/testbench.sv
// self-checking bench for the auto-reload/capture/baud timer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, countPin, triggerPin, timerIrq, rxRateTick, txRateTick;
  logic [7:0] q, sel;
  logic [15:0] v, r;
  int errorCnt = 0;
  int checksDone = 0;
  int rxCnt = 0;
  int txCnt = 0;
  int rxBase, txBase;
  int n;
  logic [3:0] be = 4'h1;
  always #20 clk = ~clk;
  arct_timer2 arct_timer2_i (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .countPin(countPin), .triggerPin(triggerPin), .timerIrq(timerIrq),
    .rxRateTick(rxRateTick), .txRateTick(txRateTick));
  arct_pin_source arct_pin_source_i (.clk(clk), .countPin(countPin), .triggerPin(triggerPin));
  // negedge sampling avoids racing the registered pulses
  always @(negedge clk) begin
    rxCnt <= rxCnt + int'(rxRateTick === 1'b1);
    txCnt <= txCnt + int'(txRateTick === 1'b1);
  end
  function automatic int expTicks(input int cycles, input logic [15:0] rl);
    return cycles / (2 * (32'h10000 - int'(rl)));
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // called just after a rising edge; holds the request until waitrequest is sampled low
  // idle edge after release keeps back-to-back calls from driving a strobe twice in one step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] d);
    bus(1'b1, lo, d[7:0]);
    bus(1'b1, hi, d[15:8]);
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    checksDone++;
    if (g !== e) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic chkRd(input string name, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(name, {8'h00, e}, {8'h00, q});
  endtask
  // rate ticks may be one off, depending on where the window falls
  task automatic chkTicks(input string name, input int e, input int g);
    checksDone++;
    if (g < e - 1 || g > e + 1) begin
      errorCnt++;
      $display("MISMATCH %s expected %0d seen %0d", name, e, g);
    end
  endtask
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    cyc(20000);
    errorCnt++;
    wrapUp();
  end
  initial begin
    void'($urandom(32'hf5d165e6));
    arct_pin_source_i.holdCycles = 12 + $urandom % 8;
    cyc(4);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) chkRd("reset", 8'hc8 + 8'(4 * i), 8'h00);
    bus(1'b1, 8'he0, 8'h5a);
    chkRd("unmapped", 8'he0, 8'h00);
    be <= 4'h0;
    bus(1'b1, arct_pkg::OFF_RELOAD_LOW, 8'ha5);
    be <= 4'h1;
    chkRd("noenable", arct_pkg::OFF_RELOAD_LOW, 8'h00);
    r = {8'($urandom), 8'h00};
    wr16(arct_pkg::OFF_COUNT_LOW, arct_pkg::OFF_COUNT_HIGH, 16'hffff);
    wr16(arct_pkg::OFF_RELOAD_LOW, arct_pkg::OFF_RELOAD_HIGH, r);
    bus(1'b1, arct_pkg::OFF_CONTROL, 8'h04);
    cyc(40);
    chkRd("ovf", arct_pkg::OFF_CONTROL, 8'h84);
    chk("irq", 16'h1, {15'h0, timerIrq});
    chkRd("reload", arct_pkg::OFF_COUNT_HIGH, r[15:8]);
    bus(1'b1, arct_pkg::OFF_CONTROL, 8'h00);
    cyc(2);
    chk("irqclr", 16'h0, {15'h0, timerIrq});
    bus(1'b0, arct_pkg::OFF_COUNT_LOW, 8'h00);
    v = {8'h00, q};
    cyc(30);
    chkRd("halt", arct_pkg::OFF_COUNT_LOW, v[7:0]);
    bus(1'b1, arct_pkg::OFF_SYSTEM, 8'h01);
    bus(1'b1, arct_pkg::OFF_CONTROL, 8'h04);
    cyc(30);
    chkRd("pdown", arct_pkg::OFF_COUNT_LOW, v[7:0]);
    bus(1'b1, arct_pkg::OFF_CONTROL, 8'h02);
    bus(1'b1, arct_pkg::OFF_SYSTEM, 8'h00);
    wr16(arct_pkg::OFF_COUNT_LOW, arct_pkg::OFF_COUNT_HIGH, 16'h00fd);
    bus(1'b1, arct_pkg::OFF_CONTROL, 8'h06);
    n = 3 + $urandom % 4;
    arct_pin_source_i.fall(1'b0, n);
    cyc(30);
    v = 16'h00fd + 16'(n);
    chkRd("extlo", arct_pkg::OFF_COUNT_LOW, v[7:0]);
    chkRd("exthi", arct_pkg::OFF_COUNT_HIGH, v[15:8]);
    v = 16'($urandom);
    wr16(arct_pkg::OFF_COUNT_LOW, arct_pkg::OFF_COUNT_HIGH, v);
    bus(1'b1, arct_pkg::OFF_CONTROL, 8'h0f);
    arct_pin_source_i.fall(1'b1, 1);
    cyc(30);
    chkRd("caplo", arct_pkg::OFF_RELOAD_LOW, v[7:0]);
    chkRd("caphi", arct_pkg::OFF_RELOAD_HIGH, v[15:8]);
    chkRd("extflag", arct_pkg::OFF_CONTROL, 8'h4f);
    bus(1'b1, arct_pkg::OFF_CONTROL, 8'h07);
    wr16(arct_pkg::OFF_COUNT_LOW, arct_pkg::OFF_COUNT_HIGH, ~v);
    arct_pin_source_i.fall(1'b1, 1);
    cyc(30);
    chkRd("trigoff", arct_pkg::OFF_CONTROL, 8'h07);
    chkRd("nocap", arct_pkg::OFF_RELOAD_LOW, v[7:0]);
    r = 16'($urandom);
    wr16(arct_pkg::OFF_RELOAD_LOW, arct_pkg::OFF_RELOAD_HIGH, r);
    bus(1'b1, arct_pkg::OFF_CONTROL, 8'h0e);
    arct_pin_source_i.fall(1'b1, 1);
    cyc(30);
    chkRd("trlo", arct_pkg::OFF_COUNT_LOW, r[7:0]);
    chkRd("trhi", arct_pkg::OFF_COUNT_HIGH, r[15:8]);
    chkRd("trflag", arct_pkg::OFF_CONTROL, 8'h4e);
    bus(1'b1, arct_pkg::OFF_CONTROL, 8'h00);
    wr16(arct_pkg::OFF_RELOAD_LOW, arct_pkg::OFF_RELOAD_HIGH, 16'hfffe);
    wr16(arct_pkg::OFF_COUNT_LOW, arct_pkg::OFF_COUNT_HIGH, 16'hfffe);
    for (int i = 0; i < 4; i++) begin
      sel = (i == 1) ? 8'h24 : (i == 3) ? 8'h14 : 8'h34;
      bus(1'b1, arct_pkg::OFF_SYSTEM, 8'(i << 1));
      bus(1'b1, arct_pkg::OFF_CONTROL, sel);
      cyc(4);
      rxBase = rxCnt;
      txBase = txCnt;
      cyc(48);
      chkTicks("rx", (i % 2 == 1 && sel[5]) ? expTicks(48, 16'hfffe) : 0, rxCnt - rxBase);
      chkTicks("tx", (i % 2 == 1 && sel[4]) ? expTicks(48, 16'hfffe) : 0, txCnt - txBase);
      chkRd("baudflag", arct_pkg::OFF_CONTROL, sel);
      bus(1'b1, arct_pkg::OFF_CONTROL, 8'h00);
    end
    bus(1'b1, arct_pkg::OFF_SYSTEM, 8'h02);
    bus(1'b1, arct_pkg::OFF_CONTROL, 8'h3c);
    arct_pin_source_i.fall(1'b1, 1);
    cyc(30);
    chkRd("baudtrig", arct_pkg::OFF_CONTROL, 8'h7c);
    chk("baudirq", 16'h1, {15'h0, timerIrq});
    wrapUp();
  end
endmodule
